// file: design/aiwf_top.sv
`timescale 1ns/1ps
`include "aiwf_defines.svh"
module aiwf_top
  import aiwf_pkg::*;
(
  input  wire logic                                 i_mclk,
  input  wire logic                                 i_rst_n,
  // Converter front end
  input  wire logic                                 i_conv_valid,
  output logic                                      o_conv_ready,
  input  wire logic [`AIWF_CHAN_W-1:0]              i_conv_chan,
  input  wire logic [`AIWF_CODE_W-1:0]              i_conv_code,
  input  wire logic                                 i_conv_over,
  input  wire logic                                 i_conv_under,
  // Static variant pins
  input  wire logic                                 i_layout_sel,
  input  wire logic [1:0]                           i_range_sel,
  input  wire logic                                 i_status_en,
  // Coupler side
  input  wire logic                                 i_hold,
  input  wire logic                                 i_rd_start,
  input  wire logic [`AIWF_CHAN_W-1:0]              i_rd_chan,
  input  wire logic                                 i_rd_next,
  output logic                                      o_rd_valid,
  output logic      [`AIWF_BYTE_W-1:0]              o_rd_byte,
  output logic                                      o_rd_last,
  output logic      [`AIWF_WORD_W-1:0]              o_snap_word,
  output logic      [`AIWF_STAT_W-1:0]              o_snap_status,
  output logic      [`AIWF_NCHAN*`AIWF_WORD_W-1:0]  o_image_word,
  output logic      [`AIWF_NCHAN*`AIWF_STAT_W-1:0]  o_image_status,
  output logic      [`AIWF_NCHAN-1:0]               o_chan_fresh,
  output logic      [`AIWF_NCHAN-1:0]               o_chan_fault
);

  // Converter results buffered ahead of formatting
  logic                      fifo_out_valid;
  logic                      fifo_out_ready;
  logic [`AIWF_ENTRY_W-1:0]  fifo_out_data;
  logic [`AIWF_ENTRY_W-1:0]  fifo_in_data;
  logic                      pop;

  assign fifo_in_data = {i_conv_chan, i_conv_over, i_conv_under, i_conv_code};

  aiwf_fifo #(
    .W     (`AIWF_ENTRY_W),
    .DEPTH (`AIWF_FIFO_DEPTH)
  ) u_fifo (
    .i_mclk      (i_mclk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (i_conv_valid),
    .o_in_ready  (o_conv_ready),
    .i_in_data   (fifo_in_data),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (fifo_out_ready),
    .o_out_data  (fifo_out_data)
  );

  // Coupler freezes the image while holding
  assign fifo_out_ready = ~i_hold;
  assign pop            = fifo_out_valid & fifo_out_ready;

  // Variant pins through the synchroniser
  logic [`AIWF_CFG_W-1:0] cfg_raw;
  logic [`AIWF_CFG_W-1:0] cfg_sync;
  aiwf_layout_type        layout;
  aiwf_range_type         range_mode;
  logic                   status_en;

  assign cfg_raw = {i_status_en, i_range_sel, i_layout_sel};

  aiwf_sync #(
    .W (`AIWF_CFG_W)
  ) u_cfg_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_async (cfg_raw),
    .o_sync  (cfg_sync)
  );

  always_comb begin
    layout    = cfg_sync[`AIWF_CFG_LAYOUT] ? AIWF_FLAGGED : AIWF_PLAIN;
    status_en = cfg_sync[`AIWF_CFG_STATEN];
    unique case (cfg_sync[`AIWF_CFG_RNG_HI:`AIWF_CFG_RNG_LO])
      `AIWF_RANGE_CUR0: range_mode = AIWF_CUR_ZERO;
      `AIWF_RANGE_LIVE: range_mode = AIWF_CUR_LIVE;
      default:          range_mode = AIWF_VOLT;
    endcase
  end

  // Status byte from range conditions
  function automatic logic [`AIWF_STAT_W-1:0] fmt_status(
    input logic over,
    input logic under_eff
  );
    logic [`AIWF_STAT_W-1:0] st;
    st                = '0;
    st[`AIWF_ST_ZERO7] = 1'b0;
    st[`AIWF_ST_OVR]   = over;
    st[`AIWF_ST_UND]   = under_eff;
    st[`AIWF_ST_ERR]   = over | under_eff;
    return st;
  endfunction : fmt_status

  // Data word for either layout
  function automatic logic [`AIWF_WORD_W-1:0] fmt_word(
    input logic [`AIWF_CODE_W-1:0] code,
    input logic                    over,
    input logic                    under_eff,
    input aiwf_layout_type         lay
  );
    logic [`AIWF_FIELD_W-1:0] sum;
    logic [`AIWF_FIELD_W-1:0] field;
    logic [`AIWF_LOW_W-1:0]   flags;
    logic [`AIWF_WORD_W-1:0]  w;
    sum   = {1'b0, code} + `AIWF_FLAG_ROUND;
    field = `AIWF_FLAG_ZERO + {1'b0, sum[`AIWF_FIELD_W-1:1]};
    flags = '0;
    w     = '0;
    if (lay == AIWF_PLAIN) begin
      if (over) begin
        w = `AIWF_PLAIN_OVER;
      end else if (under_eff) begin
        w = `AIWF_PLAIN_UNDER;
      end else begin
        w = {1'b0, code, `AIWF_PLAIN_PAD};
      end
    end else begin
      flags[`AIWF_FLAG_NM] = 1'b0;
      if (over) begin
        flags[`AIWF_FLAG_OVF] = 1'b1;
        w = {`AIWF_FLAG_FULL, flags};
      end else if (under_eff) begin
        flags[`AIWF_FLAG_OVF] = 1'b1;
        flags[`AIWF_FLAG_SC]  = 1'b1;
        w = {`AIWF_FLAG_ZERO, flags};
      end else begin
        w = {field, flags};
      end
    end
    return w;
  endfunction : fmt_word

  // Per-channel process image
  logic [`AIWF_WORD_W-1:0] word_mem_reg  [`AIWF_NCHAN];
  logic [`AIWF_WORD_W-1:0] word_mem_next [`AIWF_NCHAN];
  logic [`AIWF_STAT_W-1:0] stat_mem_reg  [`AIWF_NCHAN];
  logic [`AIWF_STAT_W-1:0] stat_mem_next [`AIWF_NCHAN];
  logic [`AIWF_NCHAN-1:0]  fresh_reg;
  logic [`AIWF_NCHAN-1:0]  fresh_next;
  logic [`AIWF_NCHAN-1:0]  fault_reg;
  logic [`AIWF_NCHAN-1:0]  fault_next;

  logic [`AIWF_CODE_W-1:0] ent_code;
  logic                    ent_over;
  logic                    ent_under_eff;
  logic [`AIWF_CHAN_W-1:0] ent_chan;
  logic [`AIWF_WORD_W-1:0] new_word;
  logic [`AIWF_STAT_W-1:0] new_stat;

  // Read sequencer
  aiwf_rd_state_type       rd_state_reg;
  aiwf_rd_state_type       rd_state_next;
  logic [`AIWF_WORD_W-1:0] snap_word_reg;
  logic [`AIWF_WORD_W-1:0] snap_word_next;
  logic [`AIWF_STAT_W-1:0] snap_stat_reg;
  logic [`AIWF_STAT_W-1:0] snap_stat_next;
  logic                    stat_incl_reg;
  logic                    stat_incl_next;
  logic [`AIWF_BYTE_W-1:0] rd_byte_reg;
  logic [`AIWF_BYTE_W-1:0] rd_byte_next;
  logic                    rd_valid_reg;
  logic                    rd_valid_next;
  logic                    rd_last_reg;
  logic                    rd_last_next;
  logic                    take_start;

  always_comb begin
    ent_code      = fifo_out_data[`AIWF_ENT_CODE_HI:`AIWF_ENT_CODE_LO];
    ent_over      = fifo_out_data[`AIWF_ENT_OVER];
    ent_chan      = fifo_out_data[`AIWF_ENT_CHAN];
    // Over range dominates; underrange only for live-zero current
    ent_under_eff = fifo_out_data[`AIWF_ENT_UNDER] & ~ent_over
                    & (range_mode == AIWF_CUR_LIVE);
    new_word      = fmt_word(ent_code, ent_over, ent_under_eff, layout);
    new_stat      = fmt_status(ent_over, ent_under_eff);
  end

  always_comb begin
    take_start = i_rd_start & (rd_state_reg == AIWF_RD_IDLE);
    fresh_next = fresh_reg;
    fault_next = fault_reg;
    for (int c = 0; c < `AIWF_NCHAN; c++) begin
      word_mem_next[c] = word_mem_reg[c];
      stat_mem_next[c] = stat_mem_reg[c];
    end
    if (take_start) begin
      fresh_next[i_rd_chan] = 1'b0;
    end
    if (pop) begin
      // Word and status written in the same cycle
      word_mem_next[ent_chan] = new_word;
      stat_mem_next[ent_chan] = new_stat;
      fault_next[ent_chan]    = new_stat[`AIWF_ST_ERR];
      // New result beats a same-cycle read clear
      fresh_next[ent_chan]    = 1'b1;
    end
  end

  always_comb begin
    rd_state_next  = rd_state_reg;
    snap_word_next = snap_word_reg;
    snap_stat_next = snap_stat_reg;
    stat_incl_next = stat_incl_reg;
    rd_byte_next   = rd_byte_reg;
    rd_valid_next  = rd_valid_reg;
    rd_last_next   = rd_last_reg;
    unique case (rd_state_reg)
      AIWF_RD_IDLE: begin
        if (take_start) begin
          // Snapshot pairs word and status of one conversion
          snap_word_next = word_mem_reg[i_rd_chan];
          snap_stat_next = stat_mem_reg[i_rd_chan];
          stat_incl_next = status_en;
          rd_byte_next   = word_mem_reg[i_rd_chan][`AIWF_WORD_W-1:`AIWF_BYTE_W];
          rd_valid_next  = 1'b1;
          rd_last_next   = 1'b0;
          rd_state_next  = AIWF_RD_HIGH;
        end
      end
      AIWF_RD_HIGH: begin
        if (i_rd_next) begin
          rd_byte_next  = snap_word_reg[`AIWF_BYTE_W-1:0];
          rd_last_next  = ~stat_incl_reg;
          rd_state_next = AIWF_RD_LOW;
        end
      end
      AIWF_RD_LOW: begin
        if (i_rd_next) begin
          if (stat_incl_reg) begin
            rd_byte_next  = snap_stat_reg;
            rd_last_next  = 1'b1;
            rd_state_next = AIWF_RD_STAT;
          end else begin
            rd_valid_next = 1'b0;
            rd_last_next  = 1'b0;
            rd_state_next = AIWF_RD_IDLE;
          end
        end
      end
      AIWF_RD_STAT: begin
        if (i_rd_next) begin
          rd_valid_next = 1'b0;
          rd_last_next  = 1'b0;
          rd_state_next = AIWF_RD_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int c = 0; c < `AIWF_NCHAN; c++) begin
        word_mem_reg[c] <= '0;
        stat_mem_reg[c] <= '0;
      end
      fresh_reg     <= '0;
      fault_reg     <= '0;
      rd_state_reg  <= AIWF_RD_IDLE;
      snap_word_reg <= '0;
      snap_stat_reg <= '0;
      stat_incl_reg <= 1'b0;
      rd_byte_reg   <= '0;
      rd_valid_reg  <= 1'b0;
      rd_last_reg   <= 1'b0;
    end else begin
      for (int c = 0; c < `AIWF_NCHAN; c++) begin
        word_mem_reg[c] <= word_mem_next[c];
        stat_mem_reg[c] <= stat_mem_next[c];
      end
      fresh_reg     <= fresh_next;
      fault_reg     <= fault_next;
      rd_state_reg  <= rd_state_next;
      snap_word_reg <= snap_word_next;
      snap_stat_reg <= snap_stat_next;
      stat_incl_reg <= stat_incl_next;
      rd_byte_reg   <= rd_byte_next;
      rd_valid_reg  <= rd_valid_next;
      rd_last_reg   <= rd_last_next;
    end
  end

  always_comb begin
    for (int c = 0; c < `AIWF_NCHAN; c++) begin
      o_image_word[c*`AIWF_WORD_W +: `AIWF_WORD_W]   = word_mem_reg[c];
      o_image_status[c*`AIWF_STAT_W +: `AIWF_STAT_W] = stat_mem_reg[c];
    end
  end

  assign o_rd_valid    = rd_valid_reg;
  assign o_rd_byte     = rd_byte_reg;
  assign o_rd_last     = rd_last_reg;
  assign o_snap_word   = snap_word_reg;
  assign o_snap_status = snap_stat_reg;
  assign o_chan_fresh  = fresh_reg;
  assign o_chan_fault  = fault_reg;

endmodule : aiwf_top

// file: shared/aiwf_defines.svh
`ifndef AIWF_DEFINES_SVH
`define AIWF_DEFINES_SVH

`define AIWF_CODE_W      12
`define AIWF_WORD_W      16
`define AIWF_STAT_W      8
`define AIWF_BYTE_W      8
`define AIWF_NCHAN       2
`define AIWF_CHAN_W      1
`define AIWF_FIFO_DEPTH  32
`define AIWF_ENTRY_W     15
`define AIWF_CFG_W       4
`define AIWF_LOW_W       3
`define AIWF_FIELD_W     13

// Fifo entry layout
`define AIWF_ENT_CODE_LO 0
`define AIWF_ENT_CODE_HI 11
`define AIWF_ENT_UNDER   12
`define AIWF_ENT_OVER    13
`define AIWF_ENT_CHAN    14

// Config pin layout after synchroniser
`define AIWF_CFG_LAYOUT  0
`define AIWF_CFG_RNG_LO  1
`define AIWF_CFG_RNG_HI  2
`define AIWF_CFG_STATEN  3

// Plain layout
`define AIWF_PLAIN_OVER  16'h7FFF
`define AIWF_PLAIN_UNDER 16'h0000
`define AIWF_PLAIN_PAD   3'h0

// Flag layout value field (word bits 15..3)
`define AIWF_FLAG_ZERO   13'h0200
`define AIWF_FLAG_FULL   13'h0A00
`define AIWF_FLAG_ROUND  13'h0001
`define AIWF_FLAG_OVF    0
`define AIWF_FLAG_SC     1
`define AIWF_FLAG_NM     2

// Status byte bits
`define AIWF_ST_ZERO7    7
`define AIWF_ST_ERR      6
`define AIWF_ST_OVR      1
`define AIWF_ST_UND      0

`define AIWF_RANGE_VOLT  2'h0
`define AIWF_RANGE_CUR0  2'h1
`define AIWF_RANGE_LIVE  2'h2

`endif

// file: shared/aiwf_pkg.sv
package aiwf_pkg;

  typedef enum logic {
    AIWF_PLAIN,
    AIWF_FLAGGED
  } aiwf_layout_type;

  typedef enum logic [1:0] {
    AIWF_VOLT,
    AIWF_CUR_ZERO,
    AIWF_CUR_LIVE
  } aiwf_range_type;

  typedef enum logic [1:0] {
    AIWF_RD_IDLE,
    AIWF_RD_HIGH,
    AIWF_RD_LOW,
    AIWF_RD_STAT
  } aiwf_rd_state_type;

endpackage : aiwf_pkg

// file: design/aiwf_sync.sv
`timescale 1ns/1ps
module aiwf_sync #(
  parameter int W = 4
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] out_reg;
  logic [W-1:0] out_next;

  // Accept a bit only once second and third stage agree
  always_comb begin
    for (int k = 0; k < W; k++) begin
      out_next[k] = (s2_reg[k] == s3_reg[k]) ? s3_reg[k] : out_reg[k];
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      out_reg <= '0;
    end else begin
      s1_reg  <= i_async;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign o_sync = out_reg;

endmodule : aiwf_sync

// file: design/aiwf_fifo.sv
`timescale 1ns/1ps
module aiwf_fifo #(
  parameter int W     = 15,
  parameter int DEPTH = 32
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rst_n,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic      [W-1:0] o_out_data
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [W-1:0]  mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] wr_ptr_next;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW-1:0] rd_ptr_next;
  logic [AW:0]   count_reg;
  logic [AW:0]   count_next;
  logic          in_ready_reg;
  logic          in_ready_next;
  logic          out_valid_reg;
  logic          out_valid_next;
  logic          push;
  logic          pop;

  always_comb begin
    push           = i_in_valid & in_ready_reg;
    pop            = out_valid_reg & i_out_ready;
    wr_ptr_next    = wr_ptr_reg;
    rd_ptr_next    = rd_ptr_reg;
    count_next     = count_reg;
    if (push) begin
      wr_ptr_next = wr_ptr_reg + AW'(1);
    end
    if (pop) begin
      rd_ptr_next = rd_ptr_reg + AW'(1);
    end
    if (push && !pop) begin
      count_next = count_reg + (AW+1)'(1);
    end else if (pop && !push) begin
      count_next = count_reg - (AW+1)'(1);
    end
    in_ready_next  = (count_next != FULL_CNT);
    out_valid_next = (count_next != '0);
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_reg    <= '0;
      rd_ptr_reg    <= '0;
      count_reg     <= '0;
      in_ready_reg  <= 1'b1;
      out_valid_reg <= 1'b0;
    end else begin
      wr_ptr_reg    <= wr_ptr_next;
      rd_ptr_reg    <= rd_ptr_next;
      count_reg     <= count_next;
      in_ready_reg  <= in_ready_next;
      out_valid_reg <= out_valid_next;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  assign o_in_ready  = in_ready_reg;
  assign o_out_valid = out_valid_reg;
  assign o_out_data  = mem_reg[rd_ptr_reg];

endmodule : aiwf_fifo

// file: sim/aiwf_top_asserts.sv
`timescale 1ns/1ps
module aiwf_top_asserts (
  input wire logic        i_mclk,
  input wire logic        i_rst_n,
  input wire logic        i_hold,
  input wire logic        i_rd_start,
  input wire logic        i_rd_next,
  input wire logic        o_conv_ready,
  input wire logic        o_rd_valid,
  input wire logic [7:0]  o_rd_byte,
  input wire logic        o_rd_last,
  input wire logic [15:0] o_snap_word,
  input wire logic [31:0] o_image_word,
  input wire logic [15:0] o_image_status,
  input wire logic [1:0]  o_chan_fault
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  last_has_valid_a: assert property (o_rd_last |-> o_rd_valid)
    else $error("last flag without valid byte");
  status_top_zero_a: assert property (!o_image_status[7] && !o_image_status[15])
    else $error("status bit seven set");
  status_res_zero_a: assert property (o_image_status[5:2] == 4'h0 &&
    o_image_status[13:10] == 4'h0) else $error("reserved status bits set");
  error_bit_or_a: assert property (o_image_status[6] == (|o_image_status[1:0]) &&
    o_image_status[14] == (|o_image_status[9:8])) else $error("error bit mismatch");
  fault_mirror_a: assert property (o_chan_fault ==
    {o_image_status[14], o_image_status[6]}) else $error("fault flag mismatch");
  first_byte_high_a: assert property (!o_rd_valid && i_rd_start |=>
    o_rd_valid && !o_rd_last && o_rd_byte == o_snap_word[15:8])
    else $error("first byte not high byte");
  second_byte_low_a: assert property ($rose(o_rd_valid) && i_rd_next |=>
    o_rd_valid && o_rd_byte == o_snap_word[7:0]) else $error("second byte not low byte");
  over_status_a: assert property ((o_image_word[15:0] == 16'h7FFF ||
    o_image_word[15:0] == 16'h5001) |-> o_image_status[7:0] == 8'h42)
    else $error("overrange word without status 42");
  inrange_pad_a: assert property (o_image_status[7:0] == 8'h00 |->
    o_image_word[2:0] == 3'h0) else $error("low bits set for good value");
  hold_freeze_a: assert property (i_hold |=> $stable(o_image_word) &&
    $stable(o_image_status)) else $error("image changed while held");
  byte_stands_a: assert property (o_rd_valid && !i_rd_next |=>
    o_rd_valid && $stable(o_rd_byte)) else $error("byte changed without advance");

  readout_c: cover property (!o_rd_valid && i_rd_start);
  overflow_c: cover property (o_image_status[7:0] == 8'h42);
  fifo_full_c: cover property (!o_conv_ready);
endmodule : aiwf_top_asserts

bind aiwf_top aiwf_top_asserts u_chk (.i_mclk, .i_rst_n, .i_hold, .i_rd_start, .i_rd_next,
  .o_conv_ready, .o_rd_valid, .o_rd_byte, .o_rd_last, .o_snap_word, .o_image_word,
  .o_image_status, .o_chan_fault);

// file: sim/aiwf_coupler_model.sv
`timescale 1ns/1ps
module aiwf_coupler_model (
  input  wire logic       i_mclk,
  output logic            o_rd_start,
  output logic            o_rd_chan,
  output logic            o_rd_next,
  input  wire logic       i_rd_valid,
  input  wire logic [7:0] i_rd_byte,
  input  wire logic       i_rd_last
);
  initial begin
    o_rd_start = 1'h0;
    o_rd_chan  = 1'h0;
    o_rd_next  = 1'h0;
  end
  // Reads n bytes, stalling gap cycles before each
  task automatic read(input logic ch, input int n, input int gap,
                      output logic [23:0] got, output logic [2:0] lasts);
    int k;
    got = 24'h0;
    lasts = 3'h0;
    o_rd_start = 1'h1;
    o_rd_chan = ch;
    @(negedge i_mclk);
    o_rd_start = 1'h0;
    for (k = 0; k < n; k++) begin
      if (gap > 0) begin
        o_rd_next = 1'h0;
        repeat (gap) @(negedge i_mclk);
      end
      got = {got[15:0], i_rd_valid ? i_rd_byte : 8'hXX};
      lasts = {lasts[1:0], i_rd_last};
      o_rd_next = 1'h1;
      @(negedge i_mclk);
    end
    o_rd_next = 1'h0;
  endtask : read
endmodule : aiwf_coupler_model

// file: sim/tb.sv
`timescale 1ns/1ps
module tb;
  import aiwf_pkg::*;
  logic        i_mclk, i_rst_n, i_conv_valid, i_conv_chan, i_conv_over, i_conv_under;
  logic        i_layout_sel, i_status_en, i_hold, conv_ready;
  logic [11:0] i_conv_code;
  logic [1:0]  i_range_sel, fresh, fault;
  logic        rd_start, rd_chan, rd_next, rd_valid, rd_last;
  logic [7:0]  rd_byte, snap_s;
  logic [31:0] img_w;
  logic [15:0] img_s;
  logic [23:0] got;
  logic [2:0]  lasts;
  int          error_cnt, total_checks, k;

  aiwf_top DUT (.i_mclk, .i_rst_n, .i_conv_valid, .o_conv_ready(conv_ready), .i_conv_chan,
    .i_conv_code, .i_conv_over, .i_conv_under, .i_layout_sel, .i_range_sel, .i_status_en,
    .i_hold, .i_rd_start(rd_start), .i_rd_chan(rd_chan), .i_rd_next(rd_next),
    .o_rd_valid(rd_valid), .o_rd_byte(rd_byte), .o_rd_last(rd_last), .o_snap_word(),
    .o_snap_status(snap_s), .o_image_word(img_w), .o_image_status(img_s),
    .o_chan_fresh(fresh), .o_chan_fault(fault));
  aiwf_coupler_model CPL (.i_mclk, .o_rd_start(rd_start), .o_rd_chan(rd_chan),
    .o_rd_next(rd_next), .i_rd_valid(rd_valid), .i_rd_byte(rd_byte), .i_rd_last(rd_last));

  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done

  task automatic push(input logic ch, input logic [11:0] c, input logic ov, input logic un);
    int n;
    n = 0;
    i_conv_valid = 1'h1;
    i_conv_chan = ch;
    i_conv_code = c;
    i_conv_over = ov;
    i_conv_under = un;
    while (conv_ready !== 1'h1 && n < 100) begin
      @(negedge i_mclk);
      n++;
    end
    if (n == 100) chk("conv ready wait", 24'h1, 24'h0);
    // Valid left high so back to back pushes keep it steady
    @(negedge i_mclk);
  endtask : push

  task automatic fmt(input logic ch, input logic [11:0] c, input logic ov, input logic un,
                     input logic [15:0] ew, input logic [7:0] es);
    push(ch, c, ov, un);
    i_conv_valid = 1'h0;
    repeat (3) @(negedge i_mclk);
    chk("image word", ew, img_w[ch*16 +: 16]);
    chk("image status", es, img_s[ch*8 +: 8]);
  endtask : fmt

  task automatic cfg(input logic l, input logic [1:0] r, input logic s);
    i_layout_sel = l;
    i_range_sel = r;
    i_status_en = s;
    repeat (6) @(negedge i_mclk);
  endtask : cfg

  initial begin
    i_mclk = 1'h0;
    forever #5 i_mclk = ~i_mclk;
  end

  initial begin
    #200000;
    error_cnt++;
    test_done();
  end

  initial begin
    i_rst_n = 1'h0;
    i_conv_valid = 1'h0;
    i_conv_chan = 1'h0;
    i_conv_code = 12'h000;
    i_conv_over = 1'h0;
    i_conv_under = 1'h0;
    i_hold = 1'h0;
    i_layout_sel = 1'h0;
    i_range_sel = 2'h0;
    i_status_en = 1'h1;
    repeat (3) @(negedge i_mclk);
    chk("reset ready", 24'h1, conv_ready);
    chk("reset image", 24'h0, img_w[23:0]);
    i_rst_n = 1'h1;
    repeat (5) @(negedge i_mclk);
    fmt(0, 12'hFFF, 0, 0, 16'h7FF8, 8'h00);
    fmt(0, 12'h800, 0, 0, 16'h4000, 8'h00);
    fmt(0, 12'h000, 0, 0, 16'h0000, 8'h00);
    fmt(1, 12'h001, 0, 0, 16'h0008, 8'h00);
    fmt(1, 12'h123, 0, 1, 16'h0918, 8'h00);
    fmt(0, 12'hFFF, 1, 0, 16'h7FFF, 8'h42);
    chk("fresh", 24'h1, fresh[0]);
    chk("fault", 24'h1, fault[0]);
    CPL.read(1'h0, 3, 0, got, lasts);
    chk("bytes", 24'h7FFF42, got);
    chk("snap status", 24'h42, snap_s);
    chk("last", 24'h1, lasts);
    chk("valid after", 24'h0, rd_valid);
    chk("fresh clear", 24'h0, fresh[0]);
    cfg(1'h0, 2'h2, 1'h1);
    fmt(0, 12'h000, 0, 1, 16'h0000, 8'h41);
    fmt(0, 12'hFFF, 1, 1, 16'h7FFF, 8'h42);
    cfg(1'h1, 2'h2, 1'h0);
    fmt(0, 12'h000, 0, 1, 16'h1003, 8'h41);
    fmt(0, 12'hFFF, 1, 0, 16'h5001, 8'h42);
    fmt(0, 12'hFFF, 0, 0, 16'h5000, 8'h00);
    fmt(0, 12'h000, 0, 0, 16'h1000, 8'h00);
    fmt(0, 12'h800, 0, 0, 16'h3000, 8'h00);
    fmt(1, 12'h001, 0, 0, 16'h1008, 8'h00);
    CPL.read(1'h1, 2, 2, got, lasts);
    chk("bytes", 24'h001008, got);
    chk("snap status", 24'h0, snap_s);
    chk("last", 24'h1, lasts);
    chk("valid after", 24'h0, rd_valid);
    cfg(1'h1, 2'h1, 1'h1);
    fmt(0, 12'h000, 0, 1, 16'h1000, 8'h00);
    i_hold = 1'h1;
    for (k = 0; k < 32; k++) push(1'h1, 12'(k), 1'h0, 1'h0);
    chk("full", 24'h0, conv_ready);
    i_conv_valid = 1'h1;
    repeat (4) @(negedge i_mclk);
    chk("refused", 24'h0, conv_ready);
    i_conv_valid = 1'h0;
    chk("held image", 24'h1008, img_w[31:16]);
    i_hold = 1'h0;
    repeat (40) @(negedge i_mclk);
    chk("drained image", 24'h1080, img_w[31:16]);
    chk("drained status", 24'h0, img_s[15:8]);
    chk("ready again", 24'h1, conv_ready);
    test_done();
  end
endmodule : tb
